/* File: hdl/dcw_pkg.sv */
package dcw_pkg;

  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] DCW_CFG_SRC_OFS   = 8'h00;
  localparam logic [7:0] DCW_CFG_MODE_OFS  = 8'h04;
  localparam logic [7:0] DCW_CFG_WDT_OFS   = 8'h08;
  localparam logic [7:0] DCW_CTRL_OFS      = 8'h0C;
  localparam logic [7:0] DCW_STATUS_OFS    = 8'h10;

  // Configuration word field positions
  localparam int DCW_WP_POS    = 0;
  localparam int DCW_TSU_POS   = 1;
  localparam int DCW_OSC_POS   = 2;
  localparam int DCW_CSM_POS   = 5;
  localparam int DCW_PINF_POS  = 7;
  localparam int DCW_POSC_POS  = 8;
  localparam int DCW_WFE_POS   = 10;
  localparam int DCW_WWD_POS   = 11;
  localparam int DCW_WPRE_POS  = 12;
  localparam int DCW_WPST_POS  = 13;
  localparam int DCW_PWM_POS   = 17;
  localparam int DCW_CFG_W     = 18;

  // Erased configuration memory reads as all ones
  localparam logic [17:0] DCW_CFG_RST = 18'h3FFFF;

  // Prescaler division ratios
  localparam logic [7:0] DCW_PRE_HI = 8'h80;
  localparam logic [7:0] DCW_PRE_LO = 8'h20;

  typedef enum logic [2:0] {
    DCW_OSC_FRC      = 3'b000,
    DCW_OSC_FRC_PLL  = 3'b001,
    DCW_OSC_PRI      = 3'b010,
    DCW_OSC_PRI_PLL  = 3'b011,
    DCW_OSC_SEC_LP   = 3'b100,
    DCW_OSC_LOW_POWER_RC_OSC     = 3'b101,
    DCW_OSC_FRC_D16  = 3'b110,
    DCW_OSC_FRC_POST = 3'b111
  } dcw_osc_e;

  typedef enum logic [1:0] {
    DCW_POSC_EXT = 2'b00,
    DCW_POSC_XT  = 2'b01,
    DCW_POSC_HS  = 2'b10,
    DCW_POSC_OFF = 2'b11
  } dcw_posc_e;

  typedef enum logic [1:0] {
    DCW_ST_RESET  = 2'b00,
    DCW_ST_LOADED = 2'b01
  } dcw_state_e;

endpackage : dcw_pkg

/* File: hdl/dcw_decoder.sv */
// Behaviour
// - Write-protect setting 0 blocks program memory writes; 1 allows them.
// - Two-speed start: run fast RC, switch to selected source when ready.
// - Source codes 111,110,001,000 select fast RC with postscaler, /16, PLL, plain.
// - Source codes 101 low-power RC, 100 secondary, 011 primary+PLL, 010 primary.
// - Switch mode 1x disables both; 01 switching only; 00 switching plus monitor.
// - Outside crystal modes, pin function 1 outputs clock, 0 gives digital I/O.
// - Primary mode 11 off, 10 high-speed crystal, 01 standard crystal, 00 external.
// - Force-enable 1 keeps watchdog and its RC on; soft enable ignored.
// - Force-enable 0 lets soft enable drive watchdog and RC oscillator.
// - Window setting 1 non-window mode, 0 window mode.
// - Prescaler setting 1 divides by 128, 0 divides by 32.
// - Postscaler ratio is two to the power of the four-bit field.
// - PWM pin setting 1 hands PWM pins to port logic, tri-stated, at reset.
// - PWM pin setting 0 gives PWM module its pins as outputs at reset; the code gives them to port logic in reset, to PWM after load.
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder (
  input  wire logic                         CLK_IN,
  input  wire logic                         RST_N_IN,
  input  wire logic [dcw_pkg::DCW_CFG_W-1:0] CFG_WORD_IN,
  input  wire logic                         SRC_READY_IN,
  input  wire logic                         WB_CYC_IN,
  input  wire logic                         WB_STB_IN,
  input  wire logic                         WB_WE_IN,
  input  wire logic [7:0]                   WB_ADR_IN,
  input  wire logic [3:0]                   WB_SEL_IN,
  input  wire logic [31:0]                  WB_DAT_IN,
  output var  logic [31:0]                  WB_DAT_OUT,
  output var  logic                         WB_ACK_OUT,
  output var  logic                         PM_WRITE_EN_OUT,
  output var  logic                         RUN_ON_FAST_RC_OUT,
  output var  logic [2:0]                   ACTIVE_OSC_OUT,
  output var  logic                         CLK_SWITCH_EN_OUT,
  output var  logic                         FAIL_SAFE_EN_OUT,
  output var  logic                         OSC_PIN_CLKOUT_OUT,
  output var  logic                         OSC_PIN_GPIO_OUT,
  output var  logic [1:0]                   PRIMARY_MODE_OUT,
  output var  logic                         WDT_RUN_OUT,
  output var  logic                         LOW_POWER_RC_OSC_ON_OUT,
  output var  logic                         WDT_WINDOW_OUT,
  output var  logic [7:0]                   WDT_PRE_DIV_OUT,
  output var  logic [15:0]                  WDT_POST_DIV_OUT,
  output var  logic                         PWM_PINS_TO_PORT_OUT,
  output var  logic                         PWM_PINS_OUTPUT_OUT
);
  import dcw_pkg::*;

  typedef struct packed {
    dcw_state_e              st;
    logic [DCW_CFG_W-1:0]    cfg;
    logic                    soft_wdt;
    logic                    src_ready;
    logic [31:0]             dat;
    logic                    ack;
    logic                    pm_we;
    logic                    on_frc;
    logic [2:0]              osc;
    logic                    csw;
    logic                    fscm;
    logic                    clkout;
    logic                    gpio;
    logic [1:0]              pmode;
    logic                    wdt_run;
    logic                    low_power_rc_osc;
    logic                    window;
    logic [7:0]              pre;
    logic [15:0]             post;
    logic                    pwm_port;
    logic                    pwm_out;
  } dcw_state_s;

  dcw_state_s r;
  dcw_state_s next_r;

  logic [2:0]  f_osc;
  logic [1:0]  f_csm;
  logic [1:0]  f_posc;
  logic [3:0]  f_post;
  logic        crystal;
  logic        wb_req;

  assign f_osc   = r.cfg[DCW_OSC_POS +: 3];
  assign f_csm   = r.cfg[DCW_CSM_POS +: 2];
  assign f_posc  = r.cfg[DCW_POSC_POS +: 2];
  assign f_post  = r.cfg[DCW_WPST_POS +: 4];
  assign crystal = (f_posc == DCW_POSC_XT) || (f_posc == DCW_POSC_HS);
  assign wb_req  = WB_CYC_IN && WB_STB_IN && !r.ack;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    if (r.st == DCW_ST_RESET) begin
      next_r.st  = DCW_ST_LOADED;
      next_r.cfg = CFG_WORD_IN;
    end
    next_r.pm_we = r.cfg[DCW_WP_POS];
    if (r.cfg[DCW_TSU_POS] && !r.src_ready) begin
      next_r.on_frc = 1'b1;
    end else begin
      next_r.on_frc = 1'b0;
    end
    if (next_r.on_frc) begin
      next_r.osc = DCW_OSC_FRC;
    end else begin
      next_r.osc = f_osc;
    end
    if (SRC_READY_IN) begin
      next_r.src_ready = 1'b1;
    end
    next_r.csw  = !f_csm[1];
    next_r.fscm = (f_csm == 2'b00);
    next_r.clkout = !crystal && r.cfg[DCW_PINF_POS];
    next_r.gpio   = !crystal && !r.cfg[DCW_PINF_POS];
    next_r.pmode = f_posc;
    next_r.wdt_run = r.cfg[DCW_WFE_POS] || r.soft_wdt;
    next_r.low_power_rc_osc    = r.cfg[DCW_WFE_POS] || r.soft_wdt;
    next_r.window = !r.cfg[DCW_WWD_POS];
    next_r.pre = r.cfg[DCW_WPRE_POS] ? DCW_PRE_HI : DCW_PRE_LO;
    next_r.post = 16'h0001 << f_post;
    next_r.pwm_port = r.cfg[DCW_PWM_POS];
    next_r.pwm_out  = !r.cfg[DCW_PWM_POS];
    // Wishbone slave, one wait state, single ack
    next_r.ack = wb_req;
    next_r.dat = 32'h0000_0000;
    if (wb_req) begin
      if (WB_WE_IN && WB_ADR_IN == DCW_CTRL_OFS && WB_SEL_IN[0]) begin
        next_r.soft_wdt = WB_DAT_IN[0];
      end
      if (!WB_WE_IN) begin
        case (WB_ADR_IN)
          DCW_CFG_SRC_OFS:  next_r.dat = {24'h00_0000, r.cfg[7:0]};
          DCW_CFG_MODE_OFS: next_r.dat = {24'h00_0000, r.cfg[15:8]};
          DCW_CFG_WDT_OFS:  next_r.dat = {30'h0000_0000, r.cfg[17:16]};
          DCW_CTRL_OFS:     next_r.dat = {31'h0000_0000, r.soft_wdt};
          DCW_STATUS_OFS:   next_r.dat = {27'h000_0000, r.osc, r.on_frc, r.wdt_run};
          default:          next_r.dat = 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r          <= '0;
      r.st       <= DCW_ST_RESET;
      r.cfg      <= DCW_CFG_RST;
      r.pre      <= DCW_PRE_HI;
      r.post     <= 16'h0001;
      r.pwm_port <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign WB_DAT_OUT           = r.dat;
  assign WB_ACK_OUT           = r.ack;
  assign PM_WRITE_EN_OUT      = r.pm_we;
  assign RUN_ON_FAST_RC_OUT   = r.on_frc;
  assign ACTIVE_OSC_OUT       = r.osc;
  assign CLK_SWITCH_EN_OUT    = r.csw;
  assign FAIL_SAFE_EN_OUT     = r.fscm;
  assign OSC_PIN_CLKOUT_OUT   = r.clkout;
  assign OSC_PIN_GPIO_OUT     = r.gpio;
  assign PRIMARY_MODE_OUT     = r.pmode;
  assign WDT_RUN_OUT          = r.wdt_run;
  assign LOW_POWER_RC_OSC_ON_OUT          = r.low_power_rc_osc;
  assign WDT_WINDOW_OUT       = r.window;
  assign WDT_PRE_DIV_OUT      = r.pre;
  assign WDT_POST_DIV_OUT     = r.post;
  assign PWM_PINS_TO_PORT_OUT = r.pwm_port;
  assign PWM_PINS_OUTPUT_OUT  = r.pwm_out;

  ////////////////////////////////////////////////////////////////////////////
  a_wp_decode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> PM_WRITE_EN_OUT == $past(r.cfg[DCW_WP_POS]))
    else $error("write protect decode wrong");
  a_tsu_fast: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    RUN_ON_FAST_RC_OUT |-> ACTIVE_OSC_OUT == DCW_OSC_FRC)
    else $error("two-speed start not on fast rc");
  a_osc_select: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (r.st == DCW_ST_LOADED && !next_r.on_frc) |=> ACTIVE_OSC_OUT == $past(f_osc))
    else $error("initial source wrong");
  a_monitor_dep: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    FAIL_SAFE_EN_OUT |-> CLK_SWITCH_EN_OUT)
    else $error("monitor without switching");
  a_pin_xtal: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !(OSC_PIN_CLKOUT_OUT && OSC_PIN_GPIO_OUT))
    else $error("osc pin both functions");
  a_wdt_forced: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && r.cfg[DCW_WFE_POS] |=> WDT_RUN_OUT && LOW_POWER_RC_OSC_ON_OUT)
    else $error("forced watchdog not running");
  a_pre_ratio: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> WDT_PRE_DIV_OUT == ($past(r.cfg[DCW_WPRE_POS]) ? 8'h80 : 8'h20))
    else $error("prescaler ratio wrong");
  a_pwm_owner: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    PWM_PINS_OUTPUT_OUT != PWM_PINS_TO_PORT_OUT)
    else $error("pwm pin owner ambiguous");
  a_cfg_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && $past(r.st) == DCW_ST_LOADED |-> $stable(r.cfg))
    else $error("configuration changed after load");

  a_tsu_release: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && r.src_ready |=> !RUN_ON_FAST_RC_OUT)
    else $error("fast rc held after source ready");

  a_osc_field: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && !r.cfg[DCW_TSU_POS] |=> ACTIVE_OSC_OUT == $past(f_osc))
    else $error("source field not applied");

  a_switch_mode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> CLK_SWITCH_EN_OUT == !$past(f_csm[1]))
    else $error("clock switching decode wrong");

  a_pin_clkout: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && !crystal |=> OSC_PIN_CLKOUT_OUT == $past(r.cfg[DCW_PINF_POS]))
    else $error("osc pin function wrong");

  a_primary_mode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> PRIMARY_MODE_OUT == $past(f_posc))
    else $error("primary mode decode wrong");

  a_wdt_soft: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED && !r.cfg[DCW_WFE_POS] |=> WDT_RUN_OUT == $past(r.soft_wdt))
    else $error("soft watchdog enable ignored");

  a_low_power_rc_osc_follow: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    LOW_POWER_RC_OSC_ON_OUT == WDT_RUN_OUT)
    else $error("low power rc state wrong");

  a_window_mode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> WDT_WINDOW_OUT == !$past(r.cfg[DCW_WWD_POS]))
    else $error("window mode decode wrong");

  a_post_ratio: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> WDT_POST_DIV_OUT == (16'h0001 << $past(f_post)))
    else $error("postscaler ratio wrong");

  a_pwm_port: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    r.st == DCW_ST_LOADED |=> PWM_PINS_TO_PORT_OUT == $past(r.cfg[DCW_PWM_POS]))
    else $error("pwm pin owner decode wrong");

  // Bus ack one cycle only
  a_ack_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("bus ack longer than one cycle");

endmodule : dcw_decoder
`default_nettype wire

/* File: test/dcw_decoder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder_tb_top;
  import dcw_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [17:0] cfg;
  logic        rdy, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic        pmw, fast, cse, fse, ck, gp, wrun, low_power_rc_osc, win, tp, po;
  logic [2:0]  osc;
  logic [1:0]  pm;
  logic [7:0]  pre;
  logic [15:0] post;
  int          fails, total_checks, cyc_cnt;
  //////////////////////////////////////////////////////////////////////////
  dcw_decoder u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CFG_WORD_IN(cfg), .SRC_READY_IN(rdy),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PM_WRITE_EN_OUT(pmw),
    .RUN_ON_FAST_RC_OUT(fast), .ACTIVE_OSC_OUT(osc), .CLK_SWITCH_EN_OUT(cse),
    .FAIL_SAFE_EN_OUT(fse), .OSC_PIN_CLKOUT_OUT(ck), .OSC_PIN_GPIO_OUT(gp),
    .PRIMARY_MODE_OUT(pm), .WDT_RUN_OUT(wrun), .LOW_POWER_RC_OSC_ON_OUT(low_power_rc_osc), .WDT_WINDOW_OUT(win),
    .WDT_PRE_DIV_OUT(pre), .WDT_POST_DIV_OUT(post), .PWM_PINS_TO_PORT_OUT(tp),
    .PWM_PINS_OUTPUT_OUT(po));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is a few hundred cycles; ceiling leaves ample slack
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fails++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Hangs here are cut by the cycle ceiling, not by a local count
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0]  b;
    logic [17:0] w;
    logic        xt;
    rst_n = 1'b0; cfg = '1; rdy = 1'b0; cyc = 1'b0; stb = 1'b0;
    we = 1'b0; adr = 8'h00; sel = 4'hF; wdat = 32'h0;
    // The eight passes walk every source code once and every switch and primary code twice
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      w = {b[2] ^ b[0], b, b[0], b[1], b[0], b[2], b[2:1], b[0], b[1:0], b, b[1], b[0]};
      xt = (w[9:8] == 2'b01) || (w[9:8] == 2'b10);
      @(posedge clk);
      rst_n <= 1'b0;
      cfg   <= w;
      rdy   <= 1'b0;
      repeat (16) @(posedge clk);
      chk("pre_rst", 32'h80, pre);
      chk("post_rst", 32'h1, post);
      chk("port_rst", 32'h1, tp);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("pm_wr", w[0], pmw);
      chk("fast", w[1], fast);
      chk("osc", w[1] ? 32'h0 : w[4:2], osc);
      chk("csw", !w[6], cse);
      chk("fsm", w[6:5] == 2'b00, fse);
      chk("clko", w[7] && !xt, ck);
      chk("gpio", !w[7] && !xt, gp);
      chk("pmode", w[9:8], pm);
      chk("wrun", w[10], wrun);
      chk("low_power_rc_osc", w[10], low_power_rc_osc);
      chk("win", !w[11], win);
      chk("pre", w[12] ? 32'h80 : 32'h20, pre);
      chk("post", 32'h1 << w[16:13], post);
      chk("port", w[17], tp);
      chk("pout", !w[17], po);
      wb(1'b0, DCW_CFG_SRC_OFS, 32'h0);
      chk("r_src", w[7:0], rd);
      wb(1'b0, DCW_CFG_MODE_OFS, 32'h0);
      chk("r_mode", w[15:8], rd);
      wb(1'b1, DCW_CFG_WDT_OFS, 32'hFFFFFFFF);
      wb(1'b0, DCW_CFG_WDT_OFS, 32'h0);
      chk("r_wdt", w[17:16], rd);
      wb(1'b0, 8'h14, 32'h0);
      chk("r_unmap", 32'h0, rd);
      wb(1'b1, DCW_CTRL_OFS, 32'h1);
      wb(1'b0, DCW_CTRL_OFS, 32'h0);
      chk("r_ctrl", 32'h1, rd);
      repeat (3) @(posedge clk);
      chk("wrun_sw", 32'h1, wrun);
      chk("low_power_rc_osc_sw", 32'h1, low_power_rc_osc);
      wb(1'b1, DCW_CTRL_OFS, 32'h0);
      repeat (3) @(posedge clk);
      chk("wrun_off", w[10], wrun);
      chk("low_power_rc_osc_off", w[10], low_power_rc_osc);
      wb(1'b0, DCW_STATUS_OFS, 32'h0);
      chk("r_stat", {w[1] ? 3'b000 : w[4:2], w[1], w[10]}, rd);
      // Word moves after load; decoded state must not follow it
      cfg <= ~w;
      rdy <= 1'b1;
      repeat (4) @(posedge clk);
      chk("hold_pm", w[0], pmw);
      chk("hold_post", 32'h1 << w[16:13], post);
      chk("fast_rdy", 32'h0, fast);
      chk("osc_rdy", w[4:2], osc);
    end
    summarize();
  end
endmodule : dcw_decoder_tb_top
`default_nettype wire
